/* File: bcg_pkg.sv */
// Package: offsets, field layout and reset values of the bridge configuration slice
package bcg_pkg;

  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_IDENTITY  = 12'h000;
  localparam logic [11:0] OFF_COMMAND   = 12'h004;
  localparam logic [11:0] OFF_EXT_PIN   = 12'h300;
  localparam logic [11:0] OFF_EXTRA_IO  = 12'h304;
  localparam logic [11:0] OFF_TIMERS    = 12'h310;

  // ==========================================
  // Extended pin register fields
  localparam int EXT_CLR_LSB    = 0;
  localparam int EXT_SET_LSB    = 3;
  localparam int EXT_OE_CLR_LSB = 6;
  localparam int EXT_OE_SET_LSB = 9;
  localparam int EXT_IN_LSB     = 12;

  // ==========================================
  // Extra in/out register fields
  localparam int XTR_CLR_LSB    = 0;
  localparam int XTR_SET_LSB    = 4;
  localparam int XTR_OE_CLR_LSB = 8;
  localparam int XTR_OE_SET_LSB = 12;
  localparam int XTR_IN_LSB     = 16;

  // ==========================================
  // Timer register fields
  localparam int TMR_REPLAY_LSB  = 0;
  localparam int TMR_REPLAY_W    = 12;
  localparam int TMR_REPLAY_EN   = 12;
  localparam int TMR_ACK_LSB     = 16;
  localparam int TMR_ACK_W       = 14;
  localparam int TMR_ACK_EN      = 30;

  // ==========================================
  // Command register bits
  localparam int CMD_IO_EN   = 0;
  localparam int CMD_MEM_EN  = 1;
  localparam int CMD_MSTR_EN = 2;
  localparam int CMD_SPC_EN  = 3;
  localparam int CMD_MWI_EN  = 4;

  // ==========================================
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

/* File: bcg_cfg_regs.sv */
// Configuration register slice: pin control, link timers, identity and command bits
// Functional notes
// - Ones written to 0x300 bits 2:0 clear extended pin 6..4 outputs.
// - Ones written to 0x300 bits 5:3 set extended pin outputs.
// - Ones written to 0x300 bits 8:6 clear extended pin drive enables.
// - Ones written to 0x300 bits 11:9 set extended pin drive enables.
// - Ones written to 0x304 bits 3:0 clear extra outputs.
// - Ones written to 0x304 bits 7:4 set extra outputs.
// - Ones to 0x304 bits 11:8 clear extra drive enables; reset zero.
// - Ones to 0x304 bits 15:12 set extra drive enables.
// - 0x304 bits 19:16 read extra input pins; bits 31:20 zero.
// - 0x310 bits 29:16 hold writable ack latency value, reset zero.
// - 0x310 bit 30 ack latency enable reads zero, not writable.
// - Retained fields survive non-power resets; only power reset clears them.
// - Non-transparent mode header layout starts at offset 0x00.
// - 0x00 bits 15:0 return fixed maker code.
// - 0x00 bits 31:16 return fixed part code.
// - Command bit 0 resets zero; gates primary I/O response.
// - Command bit 1 resets zero; gates primary memory response.
// - Command bit 2 gates primary mastering and secondary response.
// - Reverse bridge with PCI-X primary may split-complete regardless of bit 2.
// - Command bit 3 reads zero; never a special cycle target.
// - Command bit 4 reads zero; no own invalidate writes, except forwarding.
`timescale 1ns/1ns

module bcg_cfg_regs
  import bcg_pkg::*;
#(
  parameter int          EXT_PINS     = 3,
  parameter int          EXTRA_PINS   = 4,
  // Arbitrary neutral identity and replay default values
  parameter logic [15:0] MAKER_CODE   = 16'h1234,
  parameter logic [15:0] PART_CODE    = 16'h5678,
  parameter logic [11:0] REPLAY_DFLT  = 12'h0ff
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  pwr_rst_i,
  input  wire logic                  non_transparent_i,
  input  wire logic                  reverse_mode_i,
  input  wire logic                  prim_pcix_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_rd_i,
  input  wire logic [11:0]           cfg_addr_i,
  input  wire logic [3:0]            cfg_be_i,
  input  wire logic [31:0]           cfg_wdata_i,
  output logic      [31:0]           cfg_rdata_o,
  output logic                       cfg_ack_o,
  input  wire logic [EXT_PINS-1:0]   ext_pin_i,
  output logic      [EXT_PINS-1:0]   ext_pin_o,
  output logic      [EXT_PINS-1:0]   ext_pin_oe_o,
  input  wire logic [EXTRA_PINS-1:0] extra_in_i,
  output logic      [EXTRA_PINS-1:0] extra_out_o,
  output logic      [EXTRA_PINS-1:0] extra_out_oe_o,
  output logic      [11:0]           replay_limit_o,
  output logic      [13:0]           ack_latency_o,
  output logic                       ack_latency_en_o,
  output logic                       prim_io_resp_en_o,
  output logic                       prim_mem_resp_en_o,
  output logic                       prim_master_en_o,
  output logic                       split_cpl_en_o,
  output logic                       special_cycle_en_o,
  output logic                       own_mwi_en_o
);

  // ==========================================
  // Integration notes
  // Request port: one read or write pulse a cycle, never both at once.
  // Every request is acknowledged one cycle later, mapped or not.
  // Read data stands for that one acknowledge cycle only, zero otherwise.
  // Unmapped offsets read zero and swallow writes without complaint.
  // Byte enables gate each lane, so clear/set bits need their lane enabled.
  // Same write clearing and setting one bit: the set half wins.
  // Pin and pin-enable state lives on the power reset alone.
  // Reason: board logic keeps its levels through a link-level reset.
  // Limitation: a power reset drops every pin to an undriven input.
  // Timers and command bits follow both resets.
  // Sampled pin levels pass one flop; no metastability guard here.
  // Inputs are taken as synchronous to the core clock.
  // Pin outputs lag the register by one cycle, through the output flops.
  // Trade-off: one cycle of latency for glitch-free pin drive.
  // Replay interval falls back to the default while its enable is clear.
  // Ack latency enable stays low, so the programmed value is advisory.
  // Split completion enable ignores the master bit in reverse PCI-X use.
  // Special cycle and own invalidate enables are tied low.
  // Header registers vanish from the map outside non-transparent mode.
  // Command writes need the low byte lane; other lanes hold no bits here.
  // Read-back of clear and set fields shows the current stored state.
  // Reserved bits always read zero.

  // ==========================================
  // Byte-lane qualified write data
  logic [31:0] wmask;
  logic [31:0] wd;
  logic        wr_ext;
  logic        wr_xtr;
  logic        wr_tmr;
  logic        wr_cmd;
  logic        sel_ext;
  logic        sel_xtr;
  logic        sel_tmr;
  logic        sel_id;
  logic        sel_cmd;

  // Address decode shared by write and read paths
  assign sel_ext = (cfg_addr_i == OFF_EXT_PIN);
  assign sel_xtr = (cfg_addr_i == OFF_EXTRA_IO);
  assign sel_tmr = (cfg_addr_i == OFF_TIMERS);
  assign sel_id  = non_transparent_i && (cfg_addr_i == OFF_IDENTITY);
  assign sel_cmd = non_transparent_i && (cfg_addr_i == OFF_COMMAND);

  assign wmask  = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
  assign wd     = cfg_wdata_i & wmask;
  assign wr_ext = cfg_wr_i && sel_ext;
  assign wr_xtr = cfg_wr_i && sel_xtr;
  assign wr_tmr = cfg_wr_i && sel_tmr;
  assign wr_cmd = cfg_wr_i && sel_cmd;

  // ==========================================
  // Extended pins; retained fields use power reset only
  logic [EXT_PINS-1:0] ext_out;
  logic [EXT_PINS-1:0] ext_oe;
  logic [EXT_PINS-1:0] ext_in;

  always_ff @(posedge sys_clk_i) begin
    if (pwr_rst_i) begin
      ext_out <= RST_ZERO[EXT_PINS-1:0];
      ext_oe  <= RST_ZERO[EXT_PINS-1:0];
    end else if (wr_ext) begin
      // clear then set, set wins on same write
      ext_out <= (ext_out & ~wd[EXT_CLR_LSB +: EXT_PINS]) | wd[EXT_SET_LSB +: EXT_PINS];
      ext_oe  <= (ext_oe & ~wd[EXT_OE_CLR_LSB +: EXT_PINS]) | wd[EXT_OE_SET_LSB +: EXT_PINS];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      ext_in <= RST_ZERO[EXT_PINS-1:0];
    end else begin
      ext_in <= ext_pin_i;
    end
  end

  // ==========================================
  // Extra outputs and inputs
  logic [EXTRA_PINS-1:0] xtr_out;
  logic [EXTRA_PINS-1:0] xtr_oe;
  logic [EXTRA_PINS-1:0] xtr_in;

  always_ff @(posedge sys_clk_i) begin
    if (pwr_rst_i) begin
      xtr_out <= RST_ZERO[EXTRA_PINS-1:0];
      xtr_oe  <= RST_ZERO[EXTRA_PINS-1:0];
    end else if (wr_xtr) begin
      xtr_out <= (xtr_out & ~wd[XTR_CLR_LSB +: EXTRA_PINS]) | wd[XTR_SET_LSB +: EXTRA_PINS];
      xtr_oe  <= (xtr_oe & ~wd[XTR_OE_CLR_LSB +: EXTRA_PINS]) | wd[XTR_OE_SET_LSB +: EXTRA_PINS];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      xtr_in <= RST_ZERO[EXTRA_PINS-1:0];
    end else begin
      xtr_in <= extra_in_i;
    end
  end

  // ==========================================
  // Link timers
  logic [11:0] replay_val;
  logic        replay_en;
  logic [13:0] ack_val;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      replay_val <= RST_ZERO[11:0];
      replay_en  <= 1'b0;
      ack_val    <= RST_ZERO[13:0];
    end else if (wr_tmr) begin
      if (cfg_be_i[0]) begin
        replay_val[7:0] <= cfg_wdata_i[7:0];
      end
      if (cfg_be_i[1]) begin
        replay_val[11:8] <= cfg_wdata_i[11:8];
        replay_en        <= cfg_wdata_i[TMR_REPLAY_EN];
      end
      if (cfg_be_i[2]) begin
        ack_val[7:0] <= cfg_wdata_i[23:16];
      end
      if (cfg_be_i[3]) begin
        ack_val[13:8] <= cfg_wdata_i[29:24];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      replay_limit_o <= REPLAY_DFLT;
    end else begin
      replay_limit_o <= replay_en ? replay_val : REPLAY_DFLT;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      ack_latency_o    <= RST_ZERO[13:0];
      ack_latency_en_o <= 1'b0;
    end else begin
      ack_latency_o    <= ack_val;
      ack_latency_en_o <= 1'b0;
    end
  end

  // ==========================================
  // Command bits
  logic cmd_io;
  logic cmd_mem;
  logic cmd_mstr;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      cmd_io   <= 1'b0;
      cmd_mem  <= 1'b0;
      cmd_mstr <= 1'b0;
    end else if (wr_cmd && cfg_be_i[0]) begin
      cmd_io   <= cfg_wdata_i[CMD_IO_EN];
      cmd_mem  <= cfg_wdata_i[CMD_MEM_EN];
      cmd_mstr <= cfg_wdata_i[CMD_MSTR_EN];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      prim_io_resp_en_o  <= 1'b0;
      prim_mem_resp_en_o <= 1'b0;
      prim_master_en_o   <= 1'b0;
      split_cpl_en_o     <= 1'b0;
      special_cycle_en_o <= 1'b0;
      own_mwi_en_o       <= 1'b0;
    end else begin
      prim_io_resp_en_o  <= cmd_io;
      prim_mem_resp_en_o <= cmd_mem;
      prim_master_en_o   <= cmd_mstr;
      split_cpl_en_o     <= cmd_mstr || (reverse_mode_i && prim_pcix_i);
      special_cycle_en_o <= 1'b0;
      own_mwi_en_o       <= 1'b0;
    end
  end

  // ==========================================
  // Pin outputs
  // Extended pins: registered drive, held through non-power reset
  always_ff @(posedge sys_clk_i) begin
    if (pwr_rst_i) begin
      ext_pin_o    <= RST_ZERO[EXT_PINS-1:0];
      ext_pin_oe_o <= RST_ZERO[EXT_PINS-1:0];
    end else begin
      ext_pin_o    <= ext_out;
      ext_pin_oe_o <= ext_oe;
    end
  end

  // Extra outputs: same retention as the extended pins
  always_ff @(posedge sys_clk_i) begin
    if (pwr_rst_i) begin
      extra_out_o    <= RST_ZERO[EXTRA_PINS-1:0];
      extra_out_oe_o <= RST_ZERO[EXTRA_PINS-1:0];
    end else begin
      extra_out_o    <= xtr_out;
      extra_out_oe_o <= xtr_oe;
    end
  end

  // ==========================================
  // Read path; clear/set fields read back current state
  logic [31:0] rd_val;

  always_comb begin
    rd_val = RST_ZERO;
    if (sel_ext) begin
      rd_val[EXT_CLR_LSB +: EXT_PINS]    = ext_out;
      rd_val[EXT_SET_LSB +: EXT_PINS]    = ext_out;
      rd_val[EXT_OE_CLR_LSB +: EXT_PINS] = ext_oe;
      rd_val[EXT_OE_SET_LSB +: EXT_PINS] = ext_oe;
      rd_val[EXT_IN_LSB +: EXT_PINS]     = ext_in;
    end else if (sel_xtr) begin
      rd_val[XTR_CLR_LSB +: EXTRA_PINS]    = xtr_out;
      rd_val[XTR_SET_LSB +: EXTRA_PINS]    = xtr_out;
      rd_val[XTR_OE_CLR_LSB +: EXTRA_PINS] = xtr_oe;
      rd_val[XTR_OE_SET_LSB +: EXTRA_PINS] = xtr_oe;
      rd_val[XTR_IN_LSB +: EXTRA_PINS]     = xtr_in;
    end else if (sel_tmr) begin
      rd_val[TMR_REPLAY_LSB +: TMR_REPLAY_W] = replay_val;
      rd_val[TMR_REPLAY_EN]                  = replay_en;
      rd_val[TMR_ACK_LSB +: TMR_ACK_W]       = ack_val;
    end else if (sel_id) begin
      rd_val = {PART_CODE, MAKER_CODE};
    end else if (sel_cmd) begin
      rd_val[CMD_IO_EN]   = cmd_io;
      rd_val[CMD_MEM_EN]  = cmd_mem;
      rd_val[CMD_MSTR_EN] = cmd_mstr;
    end
  end

  // Read data only during the acknowledge cycle, zero otherwise
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      cfg_rdata_o <= RST_ZERO;
    end else begin
      cfg_rdata_o <= cfg_rd_i ? rd_val : RST_ZERO;
    end
  end

  // Every request acknowledged, even unmapped ones, so software never hangs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pwr_rst_i) begin
      cfg_ack_o <= 1'b0;
    end else begin
      cfg_ack_o <= cfg_rd_i || cfg_wr_i;
    end
  end

endmodule

/* File: bcg_cfg_regs_properties.sv */
// Checker: port-level properties of the configuration slice
`timescale 1ns/1ns
module bcg_cfg_regs_props
  import bcg_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        pwr_rst_i,
  input wire logic        reverse_mode_i,
  input wire logic        prim_pcix_i,
  input wire logic        cfg_wr_i,
  input wire logic        cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [3:0]  cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_ack_o,
  input wire logic [2:0]  ext_pin_o,
  input wire logic [13:0] ack_latency_o,
  input wire logic        ack_latency_en_o,
  input wire logic        prim_master_en_o,
  input wire logic        split_cpl_en_o,
  input wire logic        special_cycle_en_o,
  input wire logic        own_mwi_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || pwr_rst_i);
  // ==========================================
  // Write sequences, each followed by a quiet cycle
  sequence s_ext_wr(logic cond);
    cfg_wr_i && cfg_addr_i == OFF_EXT_PIN && cfg_be_i[0] && cond ##1 !cfg_wr_i;
  endsequence
  sequence s_ack_wr;
    cfg_wr_i && cfg_addr_i == OFF_TIMERS && cfg_be_i[3:2] == 2'h3 ##1 !cfg_wr_i;
  endsequence
  // ==========================================
  // Properties
  chk_ack_pulse: assert property ((cfg_wr_i || cfg_rd_i) |=> cfg_ack_o)
    else $error("request not acknowledged");
  chk_rdata_idle: assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h0)
    else $error("read data outside acknowledge");
  chk_ext_set: assert property
    (s_ext_wr(cfg_wdata_i[5:3] == 3'h7) |=> ext_pin_o == 3'h7)
    else $error("extended outputs not set");
  chk_ext_clr: assert property
    (s_ext_wr(cfg_wdata_i[5:0] == 6'h07) |=> ext_pin_o == 3'h0)
    else $error("extended outputs not cleared");
  chk_ack_copy: assert property
    (s_ack_wr |=> ack_latency_o == $past(cfg_wdata_i[29:16], 2))
    else $error("ack latency value not taken");
  chk_ack_en_zero: assert property (!ack_latency_en_o)
    else $error("ack latency enable set");
  chk_spc_mwi_zero: assert property (!special_cycle_en_o && !own_mwi_en_o)
    else $error("special cycle or invalidate enabled");
  chk_split_cpl: assert property
    (!$past(rst_i || pwr_rst_i) |->
     split_cpl_en_o == (prim_master_en_o || $past(reverse_mode_i && prim_pcix_i)))
    else $error("split completion enable wrong");
endmodule

/* File: bcg_board_model.sv */
// Board model: released extended pins drift to the inverse of their last level
`timescale 1ns/1ns
module bcg_board_model (
  input  wire logic [2:0] ext_pin_o,
  input  wire logic [2:0] ext_pin_oe_o,
  output logic      [2:0] ext_pin_i
);
  logic [2:0] last_lvl = 3'h5;
  // No pull resistor, so a stale level must not look like a held one
  always @(ext_pin_o or ext_pin_oe_o or last_lvl) begin
    for (int i = 0; i < 3; i++) begin
      if (ext_pin_oe_o[i] === 1'b1) begin
        last_lvl[i] = ext_pin_o[i];
      end
      ext_pin_i[i] = (ext_pin_oe_o[i] === 1'b1) ? ext_pin_o[i] : ~last_lvl[i];
    end
  end
endmodule

/* File: bcg_cfg_regs_tb.sv */
// Testbench: configuration slice against a bench model
`timescale 1ns/1ns
module bcg_cfg_regs_tb
  import bcg_pkg::*;
;
  // Arbitrary identity and replay default values
  localparam logic [15:0] MK = 16'h2a5c;
  localparam logic [15:0] PT = 16'h71e3;
  localparam logic [11:0] RD = 12'h0a5;
  logic        sys_clk_i = 0, rst_i = 0, pwr_rst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0;
  logic        non_transparent_i = 0, reverse_mode_i = 0, prim_pcix_i = 0;
  logic        cfg_ack_o, ack_latency_en_o, prim_io_resp_en_o, prim_mem_resp_en_o;
  logic        prim_master_en_o, split_cpl_en_o, special_cycle_en_o, own_mwi_en_o;
  logic [11:0] cfg_addr_i = 0, replay_limit_o, m_rep = 0;
  logic [3:0]  cfg_be_i = 0, extra_in_i = 0, extra_out_o, extra_out_oe_o, m_xo = 0, m_xoe = 0;
  logic [31:0] cfg_wdata_i = 0, cfg_rdata_o;
  logic [2:0]  ext_pin_i, ext_pin_o, ext_pin_oe_o, m_eo = 0, m_eoe = 0, m_cmd = 0;
  logic [13:0] ack_latency_o, m_ack = 0;
  logic        m_ren = 0;
  int          failures = 0, total_checks = 0;
  logic [11:0] addrs [6] = '{OFF_IDENTITY, OFF_COMMAND, OFF_EXT_PIN, OFF_EXTRA_IO,
                             OFF_TIMERS, 12'h308};

  bcg_cfg_regs #(.MAKER_CODE(MK), .PART_CODE(PT), .REPLAY_DFLT(RD)) i_bcg_cfg_regs (.*);
  bcg_board_model i_bcg_board_model (.*);
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================
  // Compare, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    case (a)
      OFF_IDENTITY: return non_transparent_i ? {PT, MK} : 32'h0;
      OFF_COMMAND:  return non_transparent_i ? {29'h0, m_cmd} : 32'h0;
      OFF_EXT_PIN:  return {17'h0, ext_pin_i, m_eoe, m_eoe, m_eo, m_eo};
      OFF_EXTRA_IO: return {12'h0, extra_in_i, m_xoe, m_xoe, m_xo, m_xo};
      OFF_TIMERS:   return {2'h0, m_ack, 3'h0, m_ren, m_rep};
      default:      return 32'h0;
    endcase
  endfunction
  task automatic check_outs();
    chk({ext_pin_o, ext_pin_oe_o, extra_out_o, extra_out_oe_o}, {m_eo, m_eoe, m_xo, m_xoe});
    chk({replay_limit_o, ack_latency_o, ack_latency_en_o}, {m_ren ? m_rep : RD, m_ack, 1'b0});
    chk({prim_master_en_o, prim_mem_resp_en_o, prim_io_resp_en_o, split_cpl_en_o},
        {m_cmd, m_cmd[2] | (reverse_mode_i & prim_pcix_i)});
    chk({special_cycle_en_o, own_mwi_en_o}, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a);
    @(negedge sys_clk_i);
    cfg_rd_i = 1;
    cfg_addr_i = a;
    @(negedge sys_clk_i);
    cfg_rd_i = 0;
    chk(cfg_rdata_o, exp_rd(a));
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    @(negedge sys_clk_i);
    cfg_wr_i = 1;
    cfg_addr_i = a;
    cfg_be_i = be;
    cfg_wdata_i = d;
    @(negedge sys_clk_i);
    cfg_wr_i = 0;
    chk(cfg_ack_o, 1'b1);
    d = d & m;
    // Set wins over clear in one write
    case (a)
      OFF_EXT_PIN: begin
        m_eo = (m_eo & ~d[2:0]) | d[5:3];
        m_eoe = (m_eoe & ~d[8:6]) | d[11:9];
      end
      OFF_EXTRA_IO: begin
        m_xo = (m_xo & ~d[3:0]) | d[7:4];
        m_xoe = (m_xoe & ~d[11:8]) | d[15:12];
      end
      OFF_TIMERS: {m_ack, m_ren, m_rep} = ({m_ack, m_ren, m_rep} & ~{m[29:16], m[12:0]})
                                          | {d[29:16], d[12:0]};
      OFF_COMMAND: if (non_transparent_i && be[0]) m_cmd = d[2:0];
      default: ;
    endcase
    @(negedge sys_clk_i);
    check_outs();
  endtask
  task automatic batch(input int n);
    logic [11:0] a;
    for (int j = 0; j < n; j++) begin
      {non_transparent_i, reverse_mode_i, prim_pcix_i, extra_in_i} = 7'($urandom);
      a = addrs[$urandom_range(5)];
      wr(a, 4'($urandom), $urandom);
      rd(a);
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    void'($urandom(28269));
    repeat (10) @(negedge sys_clk_i);
    pwr_rst_i = 0;
    @(negedge sys_clk_i);
    check_outs();
    non_transparent_i = 1;
    foreach (addrs[k]) rd(addrs[k]);
    wr(OFF_EXT_PIN, 4'hf, 32'h0000_7e38);
    wr(OFF_EXT_PIN, 4'h3, 32'h0000_01c7);
    wr(OFF_EXTRA_IO, 4'h2, 32'h00ff_f0ff);
    wr(OFF_TIMERS, 4'hf, 32'hffff_ffff);
    wr(OFF_COMMAND, 4'h1, 32'h0000_001f);
    foreach (addrs[k]) rd(addrs[k]);
    batch(60);
    // Non-power reset: pin state must survive
    rst_i = 1;
    @(negedge sys_clk_i);
    rst_i = 0;
    {m_rep, m_ren, m_ack, m_cmd} = '0;
    repeat (2) @(negedge sys_clk_i);
    check_outs();
    batch(60);
    report_and_stop();
  end
  initial begin
    #400_000;
    failures++;
    report_and_stop();
  end
endmodule
bind bcg_cfg_regs bcg_cfg_regs_props i_props (.*);
